/* core/mdc_defines.svh */
/*
  Register offsets, field positions, reset values and step constants of the
  DMA channel engine.
  Assumes inclusion by bare name from every file that uses these macros.
*/
`ifndef MDC_DEFINES_SVH
`define MDC_DEFINES_SVH

// Channel block span and per-channel offsets (low six address bits)
`define MDC_CH_SPAN 8'h40
`define MDC_R_CFG 6'h00
`define MDC_R_ADDR 6'h04
`define MDC_R_XCNT 6'h08
`define MDC_R_XMOD 6'h0C
`define MDC_R_YCNT 6'h10
`define MDC_R_YMOD 6'h14
`define MDC_R_DPTR 6'h18
`define MDC_R_CUR 6'h1C

// Engine-wide registers
`define MDC_R_CTL 8'h80
`define MDC_R_ISTAT 8'h84
`define MDC_R_IMASK 8'h88
`define MDC_R_BUSY 8'h8C

// Channel configuration fields
`define MDC_CFG_EN 0
`define MDC_CFG_FLOW_LO 1
`define MDC_CFG_FLOW_HI 3
`define MDC_CFG_2D 4
`define MDC_CFG_ISEL_LO 5
`define MDC_CFG_ISEL_HI 6
`define MDC_CFG_W 7

// Interrupt selections
`define MDC_ISEL_NONE 2'h0
`define MDC_ISEL_HALF 2'h2
`define MDC_ISEL_ROW 2'h3

// Status fields
`define MDC_IST_DONE_LO 0
`define MDC_IST_FRAC_LO 2
`define MDC_IST_W 4

// Reset values and steps
`define MDC_CFG_RST 7'h00
`define MDC_WORD_RST 32'h0000_0000
`define MDC_CNT_RST 32'h0000_0001
`define MDC_CTL_RST 2'h0
`define MDC_IST_RST 4'h0
`define MDC_WORD_BYTES 32'h0000_0004

`endif

/* core/mdc_pkg.sv */
/*
  Types of the DMA channel engine: flows, paths, states, descriptor fields.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mdc_pkg;
  typedef enum logic [2:0] {
    FL_STOP = 3'h0, FL_AUTO = 3'h1, FL_ARRAY = 3'h2,
    FL_RING = 3'h3, FL_LIST = 3'h4, FL_FULL = 3'h5
  } mdc_flow_type;
  typedef enum logic [1:0] {PA_M2P = 2'h0, PA_P2M = 2'h1, PA_M2M = 2'h2} mdc_path_type;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_FETCH = 4'h2, ST_SRC = 4'h4, ST_DST = 4'h8
  } mdc_state_type;
  typedef enum logic [2:0] {
    DF_NEXT = 3'h0, DF_ADDR = 3'h1, DF_CFG = 3'h2, DF_XCNT = 3'h3,
    DF_XMOD = 3'h4, DF_YCNT = 3'h5, DF_YMOD = 3'h6
  } mdc_field_type;
endpackage

/* core/mdc_chan_if.sv */
/*
  Bundle between the engine sequencer and one channel address generator.
  Assumes one instance per channel, all signals on the engine clock.
*/
`timescale 1ns/1ps
interface mdc_chan_if;
  logic load;
  logic step;
  logic two_d;
  logic [31:0] start;
  logic [31:0] xcnt;
  logic [31:0] xmod;
  logic [31:0] ycnt;
  logic [31:0] ymod;
  logic [31:0] cur;
  logic last;
  logic row_end;
  logic half;
  modport eng (output load, step, two_d, start, xcnt, xmod, ycnt, ymod,
               input cur, last, row_end, half);
  modport chan (input load, step, two_d, start, xcnt, xmod, ycnt, ymod,
                output cur, last, row_end, half);
endinterface

/* core/mdc_dma_chan.sv */
/*
  Address generator of one channel: 1D or 2D walk with signed strides.
  Assumes load and step never arrive together and counts of at least one.
*/
`timescale 1ns/1ps
`include "mdc_defines.svh"

module mdc_dma_chan (
  input wire logic i_clk,
  input wire logic i_rst,
  mdc_chan_if.chan cif
);
  logic [31:0] addr_reg;
  logic [31:0] xleft_reg;
  logic [31:0] yleft_reg;
  logic [31:0] xcnt_reg;

  ////////////////////////////////////////////////////////////////////////
  // Working counters, reloaded from the setup values
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      addr_reg <= `MDC_WORD_RST;
      xleft_reg <= `MDC_CNT_RST;
      yleft_reg <= `MDC_CNT_RST;
      xcnt_reg <= `MDC_CNT_RST;
    end else if (cif.load) begin
      addr_reg <= cif.start;
      xleft_reg <= cif.xcnt;
      yleft_reg <= cif.two_d ? cif.ycnt : `MDC_CNT_RST;
      xcnt_reg <= cif.xcnt;
    end else if (cif.step) begin
      if (xleft_reg == `MDC_CNT_RST) begin
        // Row end: the row stride replaces the element stride
        xleft_reg <= xcnt_reg;
        yleft_reg <= yleft_reg - `MDC_CNT_RST;
        addr_reg <= addr_reg + cif.ymod;
      end else begin
        xleft_reg <= xleft_reg - `MDC_CNT_RST;
        addr_reg <= addr_reg + cif.xmod;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Position flags of the element now addressed
  assign cif.cur = addr_reg;
  assign cif.row_end = (xleft_reg == `MDC_CNT_RST);
  assign cif.last = cif.row_end && (yleft_reg == `MDC_CNT_RST);
  assign cif.half = (xleft_reg == xcnt_reg - (xcnt_reg >> 1) + `MDC_CNT_RST);

endmodule

/* core/mdc_dma_engine.sv */
/*
  DMA engine with a source and a destination channel, register and
  descriptor flows, register port and interrupt.
  Assumes a memory port answering each request with a one-cycle ack and
  stream peers on the same clock.
*/
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "mdc_defines.svh"

module mdc_dma_engine
  import mdc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic i_prx_valid,
  input wire logic [31:0] i_prx_data,
  output logic o_prx_ready,
  output logic o_ptx_valid,
  output logic [31:0] o_ptx_data,
  input wire logic i_ptx_ready,
  output logic o_irq
);
  logic [`MDC_CFG_W-1:0] cfg_reg [2];
  logic [31:0] addr_reg [2];
  logic [31:0] xcnt_reg [2];
  logic [31:0] xmod_reg [2];
  logic [31:0] ycnt_reg [2];
  logic [31:0] ymod_reg [2];
  logic [31:0] dptr_reg [2];
  logic [1:0] ctl_reg;
  logic [`MDC_IST_W-1:0] istat_reg;
  logic [`MDC_IST_W-1:0] imask_reg;
  logic [`MDC_IST_W-1:0] ev_set;
  logic [31:0] rdata_reg;
  logic [31:0] rmux;
  logic irq_reg;
  mdc_state_type st_reg;
  mdc_flow_type fflow_reg;
  logic [1:0] run_reg;
  logic [1:0] nf_reg;
  logic [1:0] load_reg;
  logic fch_reg;
  logic [2:0] widx_reg;
  logic [31:0] fadr_reg;
  logic req_reg;
  logic we_reg;
  logic [31:0] maddr_reg;
  logic [31:0] mwdata_reg;
  logic prdy_reg;
  logic pval_reg;
  logic [31:0] pdata_reg;
  logic [1:0] used;
  logic [1:0] step;
  logic [1:0] sw_start;
  logic [1:0] sw_stop;
  logic [1:0] last;
  logic [1:0] row_end;
  logic [1:0] half;
  logic [31:0] cur [2];
  mdc_path_type path;
  mdc_field_type dfield;
  logic mem_done;
  logic fetch_end;
  logic xfer_done;
  logic go_fetch;
  logic go_xfer;
  logic fsel;
  logic blk_wr;
  logic wch;
  logic rd_istat;

  ////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic mdc_flow_type flow_of(input logic [`MDC_CFG_W-1:0] cfg);
    flow_of = mdc_flow_type'(cfg[`MDC_CFG_FLOW_HI:`MDC_CFG_FLOW_LO]);
  endfunction

  function automatic logic [1:0] isel_of(input logic [`MDC_CFG_W-1:0] cfg);
    isel_of = cfg[`MDC_CFG_ISEL_HI:`MDC_CFG_ISEL_LO];
  endfunction

  function automatic logic is_desc(input mdc_flow_type f);
    is_desc = (f != FL_STOP) && (f != FL_AUTO);
  endfunction

  // Channels taking part in each path
  function automatic logic [1:0] path_mask(input mdc_path_type p);
    unique case (p)
      PA_M2P: path_mask = 2'h1;
      PA_P2M: path_mask = 2'h2;
      PA_M2M: path_mask = 2'h3;
      default: path_mask = 2'h1;
    endcase
  endfunction

  // Descriptor length in words per flow
  function automatic logic [2:0] desc_words(input mdc_flow_type f);
    unique case (f)
      FL_RING: desc_words = 3'h2;
      FL_LIST: desc_words = 3'h4;
      FL_FULL: desc_words = 3'h7;
      default: desc_words = 3'h1;
    endcase
  endfunction

  // Target of descriptor word k
  function automatic mdc_field_type desc_field(input mdc_flow_type f, input logic [2:0] k);
    desc_field = DF_ADDR;
    unique case (f)
      FL_RING: desc_field = (k == 3'h0) ? DF_NEXT : DF_ADDR;
      FL_LIST: desc_field = (k == 3'h0) ? DF_NEXT : (k == 3'h1) ? DF_ADDR :
                            (k == 3'h2) ? DF_XCNT : DF_CFG;
      FL_FULL: desc_field = (k == 3'h0) ? DF_NEXT : (k == 3'h1) ? DF_ADDR :
                            (k == 3'h2) ? DF_CFG : (k == 3'h3) ? DF_XCNT :
                            (k == 3'h4) ? DF_XMOD : (k == 3'h5) ? DF_YCNT : DF_YMOD;
      default: desc_field = DF_ADDR;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Channel address generators
  mdc_chan_if cif [2] ();

  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign cif[g].load = load_reg[g];
    assign cif[g].step = step[g];
    assign cif[g].two_d = cfg_reg[g][`MDC_CFG_2D];
    assign cif[g].start = addr_reg[g];
    assign cif[g].xcnt = xcnt_reg[g];
    assign cif[g].xmod = xmod_reg[g];
    assign cif[g].ycnt = ycnt_reg[g];
    assign cif[g].ymod = ymod_reg[g];
    assign cur[g] = cif[g].cur;
    assign last[g] = cif[g].last;
    assign row_end[g] = cif[g].row_end;
    assign half[g] = cif[g].half;
    mdc_dma_chan u_chan (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .cif(cif[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Common decode
  assign path = mdc_path_type'(ctl_reg);
  assign used = path_mask(path);
  assign blk_wr = i_reg_wr && !i_reg_addr[7];
  assign wch = i_reg_addr[6];
  assign rd_istat = i_reg_rd && (i_reg_addr == `MDC_R_ISTAT);
  assign mem_done = req_reg && i_mem_ack;
  assign dfield = desc_field(fflow_reg, widx_reg);
  assign fetch_end = (st_reg == ST_FETCH) && mem_done &&
                     (widx_reg == desc_words(fflow_reg) - 3'h1);
  assign go_fetch = |nf_reg;
  assign fsel = !nf_reg[0];
  assign go_xfer = ((run_reg & used) == used) && !(|load_reg);

  // Configuration writes that start or stop a channel
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      sw_start[c] = blk_wr && (wch == c[0]) && (i_reg_addr[5:0] == `MDC_R_CFG) &&
                    i_reg_wdata[`MDC_CFG_EN];
      sw_stop[c] = blk_wr && (wch == c[0]) && (i_reg_addr[5:0] == `MDC_R_CFG) &&
                   !i_reg_wdata[`MDC_CFG_EN];
    end
  end

  // End of one element on the destination side
  always_comb begin
    xfer_done = 1'b0;
    if (st_reg == ST_DST) begin
      xfer_done = (path == PA_M2P) ? (pval_reg && i_ptx_ready) : mem_done;
    end
  end

  // Channel steps and interrupt events
  always_comb begin
    ev_set = `MDC_IST_RST;
    for (int c = 0; c < 2; c++) begin
      step[c] = xfer_done && used[c] && !last[c];
      if (xfer_done && used[c] && last[c] && (isel_of(cfg_reg[c]) != `MDC_ISEL_NONE)) begin
        ev_set[`MDC_IST_DONE_LO + c] = 1'b1;
      end
      if (step[c] && (((isel_of(cfg_reg[c]) == `MDC_ISEL_HALF) && half[c]) ||
                      ((isel_of(cfg_reg[c]) == `MDC_ISEL_ROW) && row_end[c]))) begin
        ev_set[`MDC_IST_FRAC_LO + c] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Setup registers, written by software or by descriptor fetch
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int c = 0; c < 2; c++) begin
        cfg_reg[c] <= `MDC_CFG_RST;
        addr_reg[c] <= `MDC_WORD_RST;
        xcnt_reg[c] <= `MDC_CNT_RST;
        xmod_reg[c] <= `MDC_WORD_BYTES;
        ycnt_reg[c] <= `MDC_CNT_RST;
        ymod_reg[c] <= `MDC_WORD_BYTES;
        dptr_reg[c] <= `MDC_WORD_RST;
      end
    end else begin
      if (blk_wr) begin
        case (i_reg_addr[5:0])
          `MDC_R_CFG: cfg_reg[wch] <= i_reg_wdata[`MDC_CFG_W-1:0];
          `MDC_R_ADDR: addr_reg[wch] <= i_reg_wdata;
          `MDC_R_XCNT: xcnt_reg[wch] <= i_reg_wdata;
          `MDC_R_XMOD: xmod_reg[wch] <= i_reg_wdata;
          `MDC_R_YCNT: ycnt_reg[wch] <= i_reg_wdata;
          `MDC_R_YMOD: ymod_reg[wch] <= i_reg_wdata;
          `MDC_R_DPTR: dptr_reg[wch] <= i_reg_wdata;
          default: ;
        endcase
      end
      if ((st_reg == ST_FETCH) && mem_done) begin
        // Descriptor word lands in its setup register
        unique case (dfield)
          DF_NEXT: dptr_reg[fch_reg] <= i_mem_rdata;
          DF_ADDR: addr_reg[fch_reg] <= i_mem_rdata;
          DF_CFG: cfg_reg[fch_reg] <= {i_mem_rdata[`MDC_CFG_W-1:1], 1'b1};
          DF_XCNT: xcnt_reg[fch_reg] <= i_mem_rdata;
          DF_XMOD: xmod_reg[fch_reg] <= i_mem_rdata;
          DF_YCNT: ycnt_reg[fch_reg] <= i_mem_rdata;
          DF_YMOD: ymod_reg[fch_reg] <= i_mem_rdata;
          default: ;
        endcase
        if (fetch_end && (fflow_reg == FL_ARRAY)) begin
          dptr_reg[fch_reg] <= dptr_reg[fch_reg] + `MDC_WORD_BYTES;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel run, fetch-pending and reload flags
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_reg <= 2'h0;
      nf_reg <= 2'h0;
      load_reg <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        load_reg[c] <= 1'b0;
        if (sw_stop[c]) begin
          run_reg[c] <= 1'b0;
          nf_reg[c] <= 1'b0;
        end else if (sw_start[c]) begin
          if (is_desc(flow_of(i_reg_wdata[`MDC_CFG_W-1:0]))) begin
            run_reg[c] <= 1'b0;
            nf_reg[c] <= 1'b1;
          end else begin
            run_reg[c] <= 1'b1;
            load_reg[c] <= 1'b1;
          end
        end else if (fetch_end && (fch_reg == c[0])) begin
          run_reg[c] <= 1'b1;
          load_reg[c] <= 1'b1;
        end else if (xfer_done && used[c] && last[c]) begin
          if (flow_of(cfg_reg[c]) == FL_STOP) begin
            run_reg[c] <= 1'b0;
          end else if (flow_of(cfg_reg[c]) == FL_AUTO) begin
            load_reg[c] <= 1'b1;
          end else begin
            run_reg[c] <= 1'b0;
            nf_reg[c] <= 1'b1;
          end
        end
        if ((st_reg == ST_IDLE) && go_fetch && (fsel == c[0])) begin
          nf_reg[c] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer with memory and stream ports
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_reg <= ST_IDLE;
      fflow_reg <= FL_STOP;
      fch_reg <= 1'b0;
      widx_reg <= 3'h0;
      fadr_reg <= `MDC_WORD_RST;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      maddr_reg <= `MDC_WORD_RST;
      mwdata_reg <= `MDC_WORD_RST;
      prdy_reg <= 1'b0;
      pval_reg <= 1'b0;
      pdata_reg <= `MDC_WORD_RST;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
          if (go_fetch) begin
            // Descriptor fetch starts at the channel pointer
            st_reg <= ST_FETCH;
            fch_reg <= fsel;
            fflow_reg <= flow_of(cfg_reg[fsel]);
            widx_reg <= 3'h0;
            fadr_reg <= dptr_reg[fsel] + `MDC_WORD_BYTES;
            req_reg <= 1'b1;
            we_reg <= 1'b0;
            maddr_reg <= dptr_reg[fsel];
          end else if (go_xfer) begin
            st_reg <= ST_SRC;
            if (path == PA_P2M) begin
              prdy_reg <= 1'b1;
            end else begin
              req_reg <= 1'b1;
              we_reg <= 1'b0;
              maddr_reg <= cur[0];
            end
          end
        end
        ST_FETCH: begin
          if (fetch_end) begin
            st_reg <= ST_IDLE;
            req_reg <= 1'b0;
          end else if (mem_done) begin
            maddr_reg <= fadr_reg;
            fadr_reg <= fadr_reg + `MDC_WORD_BYTES;
            widx_reg <= widx_reg + 3'h1;
          end
        end
        ST_SRC: begin
          if (path == PA_P2M) begin
            if (prdy_reg && i_prx_valid) begin
              st_reg <= ST_DST;
              prdy_reg <= 1'b0;
              req_reg <= 1'b1;
              we_reg <= 1'b1;
              maddr_reg <= cur[1];
              mwdata_reg <= i_prx_data;
            end
          end else if (mem_done) begin
            st_reg <= ST_DST;
            if (path == PA_M2P) begin
              req_reg <= 1'b0;
              pval_reg <= 1'b1;
              pdata_reg <= i_mem_rdata;
            end else begin
              we_reg <= 1'b1;
              maddr_reg <= cur[1];
              mwdata_reg <= i_mem_rdata;
            end
          end
        end
        ST_DST: begin
          if (xfer_done) begin
            st_reg <= ST_IDLE;
            req_reg <= 1'b0;
            we_reg <= 1'b0;
            pval_reg <= 1'b0;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Engine control, sticky status and mask
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctl_reg <= `MDC_CTL_RST;
      imask_reg <= `MDC_IST_RST;
      istat_reg <= `MDC_IST_RST;
      irq_reg <= 1'b0;
    end else begin
      if (i_reg_wr && (i_reg_addr == `MDC_R_CTL)) begin
        ctl_reg <= i_reg_wdata[1:0];
      end
      if (i_reg_wr && (i_reg_addr == `MDC_R_IMASK)) begin
        imask_reg <= i_reg_wdata[`MDC_IST_W-1:0];
      end
      // Read clears, a new event in the same cycle survives
      istat_reg <= (rd_istat ? `MDC_IST_RST : istat_reg) | ev_set;
      irq_reg <= |(istat_reg & imask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read path
  always_comb begin
    rmux = `MDC_WORD_RST;
    if (i_reg_addr[7]) begin
      case (i_reg_addr)
        `MDC_R_CTL: rmux = {30'h0, ctl_reg};
        `MDC_R_ISTAT: rmux = {28'h0, istat_reg};
        `MDC_R_IMASK: rmux = {28'h0, imask_reg};
        `MDC_R_BUSY: rmux = {24'h0, st_reg, nf_reg, run_reg};
        default: ;
      endcase
    end else begin
      case (i_reg_addr[5:0])
        `MDC_R_CFG: rmux = {25'h0, cfg_reg[wch]};
        `MDC_R_ADDR: rmux = addr_reg[wch];
        `MDC_R_XCNT: rmux = xcnt_reg[wch];
        `MDC_R_XMOD: rmux = xmod_reg[wch];
        `MDC_R_YCNT: rmux = ycnt_reg[wch];
        `MDC_R_YMOD: rmux = ymod_reg[wch];
        `MDC_R_DPTR: rmux = dptr_reg[wch];
        `MDC_R_CUR: rmux = cur[wch];
        default: ;
      endcase
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= `MDC_WORD_RST;
    end else begin
      rdata_reg <= i_reg_rd ? rmux : `MDC_WORD_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign o_reg_rdata = rdata_reg;
  assign o_mem_req = req_reg;
  assign o_mem_we = we_reg;
  assign o_mem_addr = maddr_reg;
  assign o_mem_wdata = mwdata_reg;
  assign o_prx_ready = prdy_reg;
  assign o_ptx_valid = pval_reg;
  assign o_ptx_data = pdata_reg;
  assign o_irq = irq_reg;

endmodule

/* testbench/mdc_mem_model.sv */
/* Memory side partner: word store, prompt or slow ack.
   Assumes byte addresses below 8'h100. */
`timescale 1ns/1ps
module mdc_mem_model (
  input wire logic i_clk,
  input wire logic i_slow,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [31:0] mem [0:63];
  logic [1:0] wait_cnt = 2'h0;
  initial o_ack = 1'b0;
  initial o_rdata = 32'h0;
  // One word per request; read data valid in the ack cycle only
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      wait_cnt <= wait_cnt + 2'h1;
      if (!i_slow || wait_cnt == 2'h3) begin
        wait_cnt <= 2'h0;
        o_ack <= 1'b1;
        if (i_we) mem[i_addr[7:2]] <= i_wdata;
        else o_rdata <= mem[i_addr[7:2]];
      end
    end
  end
endmodule

/* testbench/mdc_dma_monitor.sv */
/* Port checker of the DMA engine.
   Assumes a bind from the bench top. */
`timescale 1ns/1ps
module mdc_dma_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [31:0] o_mem_addr,
  input wire logic [31:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [31:0] i_mem_rdata,
  input wire logic i_prx_valid,
  input wire logic [31:0] i_prx_data,
  input wire logic o_prx_ready,
  input wire logic o_ptx_valid,
  input wire logic [31:0] o_ptx_data,
  input wire logic i_ptx_ready
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_req_hold;
    o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we)
      && (!o_mem_we || $stable(o_mem_wdata));
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request changed");
  property p_rd_idle;
    !i_reg_rd |=> o_reg_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_ptx_hold;
    o_ptx_valid && !i_ptx_ready |=> o_ptx_valid && $stable(o_ptx_data);
  endproperty
  a_ptx_hold: assert property (p_ptx_hold) else $error("stream word dropped");
  property p_ptx_drop;
    o_ptx_valid && i_ptx_ready |=> !o_ptx_valid [*2];
  endproperty
  a_ptx_drop: assert property (p_ptx_drop) else $error("stream valid too soon");
  property p_ptx_src;
    $rose(o_ptx_valid) |-> $past(o_mem_req) && !$past(o_mem_we) && $past(i_mem_ack)
      && o_ptx_data == $past(i_mem_rdata);
  endproperty
  a_ptx_src: assert property (p_ptx_src) else $error("stream word not read");
  property p_prx_gap;
    o_prx_ready && i_prx_valid |=> !o_prx_ready [*2];
  endproperty
  a_prx_gap: assert property (p_prx_gap) else $error("ready too soon");
  property p_prx_write;
    o_prx_ready && i_prx_valid |=> o_mem_req && o_mem_we && o_mem_wdata == $past(i_prx_data);
  endproperty
  a_prx_write: assert property (p_prx_write) else $error("taken word not written");
  property p_wr_end;
    o_mem_req && o_mem_we && i_mem_ack |=> !o_mem_req;
  endproperty
  a_wr_end: assert property (p_wr_end) else $error("request after write");
  // Main scenarios seen
  c_ptx: cover property (o_ptx_valid && i_ptx_ready);
  c_prx: cover property (o_prx_ready && i_prx_valid);
  c_slow: cover property ((o_mem_req && !i_mem_ack) [*3]);
endmodule

/* testbench/test_mdc_dma_engine.sv */
/* Bench of the DMA engine: register tasks, memory partner, streams.
   Assumes the engine, its package and defines are compiled first. */
`timescale 1ns/1ps
`include "mdc_defines.svh"
module test_mdc_dma_engine;
  logic i_clk = 1'b0, i_rst = 1'b1, i_reg_wr = 1'b0, i_reg_rd = 1'b0, slow = 1'b0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0, i_prx_data = 32'h0, o_reg_rdata, o_mem_addr;
  logic [31:0] o_mem_wdata, i_mem_rdata, o_ptx_data;
  logic o_mem_req, o_mem_we, i_mem_ack, o_prx_ready, o_ptx_valid, o_irq;
  logic i_prx_valid = 1'b0, i_ptx_ready = 1'b0;
  logic [31:0] got [$];
  logic [39:0] tbl [6];
  int error_cnt = 0, n_compared = 0, prx_n = 0, prx_lim = 0;
  always #12.5 i_clk = ~i_clk;
  mdc_dma_engine uut (.i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack),
    .i_mem_rdata(i_mem_rdata), .i_prx_valid(i_prx_valid), .i_prx_data(i_prx_data),
    .o_prx_ready(o_prx_ready), .o_ptx_valid(o_ptx_valid), .o_ptx_data(o_ptx_data),
    .i_ptx_ready(i_ptx_ready), .o_irq(o_irq));
  mdc_mem_model mdl (.i_clk(i_clk), .i_slow(slow), .i_req(o_mem_req), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  // Stream peers: stalling sink, counting source
  always @(posedge i_clk) begin
    if (o_ptx_valid && i_ptx_ready) got.push_back(o_ptx_data);
    i_ptx_ready <= ~i_ptx_ready;
    if (o_prx_ready && i_prx_valid) prx_n = prx_n + 1;
    i_prx_valid <= prx_n < prx_lim;
    i_prx_data <= prx_n;
  end
  function automatic logic [31:0] pat(input int i);
    pat = 32'hA500_0000 + i;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    chk($sformatf("reg %h", a), exp, o_reg_rdata);
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 400 && got.size() < n; i++) @(posedge i_clk);
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial begin
    repeat (20000) @(posedge i_clk);
    error_cnt++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    for (int i = 0; i < 64; i++) mdl.mem[i] = pat(i);
    tbl = '{{8'h00, 32'h0}, {8'h08, 32'h1}, {8'h4C, 32'h4}, {8'h84, 32'h0},
      {8'h90, 32'h0}, {8'h8C, 32'h10}};
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    foreach (tbl[i]) rd(tbl[i][39:32], tbl[i][31:0]);
    // Stop flow, negative stride, done interrupt
    wr(`MDC_R_IMASK, 32'h1);
    wr(`MDC_R_ADDR, 32'h10);
    wr(`MDC_R_XCNT, 32'h3);
    wr(`MDC_R_XMOD, 32'hFFFF_FFFC);
    wr(`MDC_R_CFG, 32'h21);
    wait_got(3);
    repeat (4) @(negedge i_clk);
    for (int i = 0; i < 3; i++) chk("stride", pat(4 - i), got[i]);
    chk("irq", 1'b1, o_irq);
    rd(`MDC_R_ISTAT, 32'h1);
    rd(`MDC_R_BUSY, 32'h10);
    @(negedge i_clk);
    chk("irq", 1'b0, o_irq);
    chk("count", 32'd3, got.size());
    // Circular peripheral to memory, slow memory, half point
    slow = 1'b1;
    wr(`MDC_R_IMASK, 32'hF);
    wr(`MDC_R_CTL, 32'h1);
    wr(8'h44, 32'h80);
    wr(8'h48, 32'h4);
    wr(8'h40, 32'h43);
    prx_lim = 6;
    for (int i = 0; i < 400 && prx_n < 6; i++) @(posedge i_clk);
    repeat (12) @(posedge i_clk);
    wr(8'h40, 32'h0);
    // Stopped channel still waits for one word
    prx_lim = 7;
    for (int i = 0; i < 400 && prx_n < 7; i++) @(posedge i_clk);
    repeat (12) @(posedge i_clk);
    chk("irq", 1'b1, o_irq);
    rd(`MDC_R_ISTAT, 32'hA);
    for (int i = 0; i < 4; i++) chk("wrap", (i < 3) ? i + 4 : i, mdl.mem[32 + i]);
    // Chained four-word list, then stop
    slow = 1'b0;
    wr(`MDC_R_CTL, 32'h0);
    mdl.mem[16:23] = '{32'h50, 32'h0, 32'h2, 32'h9, 32'h0, 32'h20, 32'h1, 32'h1};
    got.delete();
    wr(`MDC_R_XMOD, 32'h4);
    wr(`MDC_R_DPTR, 32'h40);
    wr(`MDC_R_CFG, 32'h9);
    wait_got(3);
    chk("list0", pat(0), got[0]);
    chk("list1", pat(1), got[1]);
    chk("list2", pat(8), got[2]);
    // Two-word ring of ping-pong buffers
    mdl.mem[24:27] = '{32'h68, 32'h4, 32'h60, 32'h24};
    got.delete();
    wr(`MDC_R_XCNT, 32'h1);
    wr(`MDC_R_DPTR, 32'h60);
    wr(`MDC_R_CFG, 32'h7);
    wait_got(3);
    wr(`MDC_R_CFG, 32'h0);
    repeat (20) @(posedge i_clk);
    for (int i = 0; i < 3; i++) chk("ring", pat(i[0] ? 9 : 1), got[i]);
    // Full descriptor in 2D with row interrupts, then array of bases
    mdl.mem[36:42] = '{32'h0, 32'h0, 32'h71, 32'h2, 32'h4, 32'h2, 32'h8};
    mdl.mem[44:45] = '{32'h20, 32'h0};
    got.delete();
    wr(`MDC_R_DPTR, 32'h90);
    wr(`MDC_R_CFG, 32'hB);
    wait_got(4);
    rd(`MDC_R_ISTAT, 32'h5);
    wr(`MDC_R_DPTR, 32'hB0);
    wr(`MDC_R_CFG, 32'h15);
    wait_got(9);
    wr(`MDC_R_CFG, 32'h0);
    repeat (30) @(posedge i_clk);
    for (int i = 0; i < 9; i++)
      chk("2d", pat(i % 4 * 3 / 2 + (i / 4 == 1 ? 8 : 0)), got[i]);
    // Memory to memory over both channels
    wr(`MDC_R_CTL, 32'h2);
    wr(`MDC_R_ADDR, 32'h08);
    wr(`MDC_R_XCNT, 32'h2);
    wr(`MDC_R_XMOD, 32'h4);
    wr(8'h44, 32'hC0);
    wr(8'h48, 32'h2);
    wr(8'h40, 32'h21);
    wr(`MDC_R_CFG, 32'h21);
    repeat (60) @(posedge i_clk);
    chk("copy0", pat(2), mdl.mem[48]);
    chk("copy1", pat(3), mdl.mem[49]);
    rd(`MDC_R_ISTAT, 32'h3);
    tally_and_finish;
  end
endmodule
bind mdc_dma_engine mdc_dma_monitor mon (.*);
